// >>> rtl/le_munge_defs.svh
`ifndef LE_MUNGE_DEFS_SVH
`define LE_MUNGE_DEFS_SVH
`define MUNGE_SZ8 3'h0
`define MUNGE_SZ4 3'h4
`define MUNGE_SZ2 3'h6
`define MUNGE_SZ1 3'h7
`define INSN_STEP 32'h0000_0004
`define RESET_PC 32'h0000_0100
`define DW_MASK 32'hFFFF_FFF8
`define PAGE_MASK 32'hFFFF_F000
`define RESET_MSW 2'h0
`endif

// >>> rtl/le_munge_pkg.sv
package le_munge_pkg;
  typedef enum logic [1:0] {SZ1, SZ2, SZ4, SZ8} opsize_t;
  typedef enum logic [1:0] {ACC_SCALAR, ACC_MULTIPLE, ACC_STRING} acc_kind_t;
  typedef struct packed {
    logic valid;
    acc_kind_t kind;
    opsize_t size;
    logic [31:0] ea;
  } dreq_t;
  typedef struct packed {
    logic valid;
    logic [31:0] addr;
    opsize_t size;
    logic restartable;
  } mreq_t;
  typedef struct packed {
    logic little_endian_select;
    logic exception_endian_select;
  } machine_state_word_t;
endpackage : le_munge_pkg

// >>> rtl/ea_munge.sv
`timescale 1ns/100ps
`include "le_munge_defs.svh"
module ea_munge
  import le_munge_pkg::*;
(
  input wire logic [31:0] ea,
  input wire le_munge_pkg::opsize_t size,
  input wire logic le,
  output logic [31:0] addr,
  output logic aligned
);
  logic [2:0] xor_val;
  logic [2:0] low_mask;
  assign xor_val = !le ? 3'h0 : (size == SZ8) ? `MUNGE_SZ8 : (size == SZ4) ? `MUNGE_SZ4 :
                   (size == SZ2) ? `MUNGE_SZ2 : `MUNGE_SZ1;
  assign low_mask = (size == SZ8) ? 3'h7 : (size == SZ4) ? 3'h3 : (size == SZ2) ? 3'h1 : 3'h0;
  assign aligned = (ea[2:0] & low_mask) == 3'h0;
  assign addr = {ea[31:3], ea[2:0] ^ xor_val};
endmodule : ea_munge

// >>> rtl/le_addr_path.sv
`timescale 1ns/100ps
`include "le_munge_defs.svh"
// What this block does
// - Little-endian instruction fetch address is XORed with 100 before memory.
// - Instructions are aligned words; sequential fetch advances by four.
// - Link and exception-saved addresses are unmunged effective addresses.
// - Relative branch targets use unmunged branch address plus offset.
// - Absolute branch targets are unmunged effective addresses.
// - Little-endian multiple and string accesses raise alignment exception.
// - Misaligned little-endian scalar within a double word completes; spanning faults.
// - Multiple accesses need word alignment; string accesses accept any alignment.
// - Big-endian addresses pass through unmodified.
// - Aligned single-register accesses are never marked restartable.
// - Misaligned accesses restartable on boundary crossing or in little-endian.
// - Multiple and string restartable when crossing a boundary.
// - Restarted accesses may repeat bytes already transferred.
// - Accesses inside a block translation area never count as crossing.
// - Data munge XOR: 8 none, 4 with 100, 2 with 110, 1 with 111.
// - Endian select bits: zero big-endian, one little-endian.
// - On exception, exception endian select copies into current select.
module le_addr_path
  import le_munge_pkg::*;
(
  input wire logic CLK,
  input wire logic ARST_N,
  input wire logic MSW_WR,
  input wire le_munge_pkg::machine_state_word_t MSW_IN,
  input wire logic EXC_TAKE,
  input wire logic [31:0] EXC_VECTOR,
  input wire logic FETCH_ADV,
  input wire logic BR_TAKE,
  input wire logic BR_ABS,
  input wire logic BR_LINK,
  input wire logic [31:0] BR_OFFSET,
  input wire le_munge_pkg::dreq_t DREQ,
  input wire logic IN_BLOCK_AREA,
  output le_munge_pkg::machine_state_word_t MSW,
  output logic [31:0] FETCH_ADDR,
  output logic [31:0] PC,
  output logic [31:0] LINK_ADDR,
  output logic [31:0] SAVED_PC,
  output le_munge_pkg::mreq_t MREQ,
  output logic ALIGN_EXC
);
  machine_state_word_t msw_r, msw_nxt;
  logic [31:0] pc_r, pc_nxt, link_r, saved_r;
  mreq_t mreq_r, mreq_nxt;
  logic align_exc_r, align_exc_nxt;
  logic [31:0] d_addr, end_ea, br_target;
  logic d_aligned, spans_dw, crosses_page, crosses, le_on, fault, restart_ok;
  logic [3:0] size_bytes;

  assign le_on = msw_r.little_endian_select;
  assign FETCH_ADDR = {pc_r[31:3], pc_r[2:0] ^ (le_on ? `MUNGE_SZ4 : 3'h0)};
  assign br_target = BR_ABS ? {BR_OFFSET[31:2], 2'h0} : pc_r + {BR_OFFSET[31:2], 2'h0};

  always_comb begin
    msw_nxt = msw_r;
    if (MSW_WR) begin
      msw_nxt = MSW_IN;
    end
    if (EXC_TAKE) begin
      msw_nxt.little_endian_select = msw_r.exception_endian_select;
    end
  end

  always_comb begin
    pc_nxt = pc_r;
    if (EXC_TAKE) begin
      pc_nxt = EXC_VECTOR;
    end else if (BR_TAKE) begin
      pc_nxt = br_target;
    end else if (FETCH_ADV) begin
      pc_nxt = pc_r + `INSN_STEP;
    end
  end

  ea_munge u_munge (
    .ea(DREQ.ea),
    .size(DREQ.size),
    .le(le_on),
    .addr(d_addr),
    .aligned(d_aligned)
  );

  assign size_bytes = (DREQ.size == SZ8) ? 4'h8 : (DREQ.size == SZ4) ? 4'h4 :
                      (DREQ.size == SZ2) ? 4'h2 : 4'h1;
  assign end_ea = DREQ.ea + {28'h0, size_bytes} - 32'h0000_0001;
  assign spans_dw = (DREQ.ea & `DW_MASK) != (end_ea & `DW_MASK);
  assign crosses_page = ((DREQ.ea & `PAGE_MASK) != (end_ea & `PAGE_MASK)) && !IN_BLOCK_AREA;
  assign crosses = crosses_page;

  assign fault = DREQ.valid && (
    (le_on && DREQ.kind != ACC_SCALAR) ||
    (le_on && DREQ.kind == ACC_SCALAR && !d_aligned && spans_dw) ||
    (DREQ.kind == ACC_MULTIPLE && DREQ.ea[1:0] != 2'h0));

  assign restart_ok = (DREQ.kind == ACC_SCALAR) ? (!d_aligned && (crosses || le_on)) : crosses;

  always_comb begin
    mreq_nxt = '0;
    align_exc_nxt = fault;
    if (DREQ.valid && !fault) begin
      mreq_nxt.valid = 1'b1;
      mreq_nxt.addr = (DREQ.kind == ACC_SCALAR) ? d_addr : DREQ.ea;
      mreq_nxt.size = DREQ.size;
      mreq_nxt.restartable = restart_ok;
    end
  end

  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      msw_r <= `RESET_MSW;
      pc_r <= `RESET_PC;
      link_r <= 32'h0;
      saved_r <= 32'h0;
      mreq_r <= '0;
      align_exc_r <= 1'b0;
    end else begin
      msw_r <= msw_nxt;
      pc_r <= pc_nxt;
      if (BR_TAKE && BR_LINK && !EXC_TAKE) begin
        link_r <= pc_r + `INSN_STEP;
      end
      if (EXC_TAKE) begin
        saved_r <= pc_r;
      end
      mreq_r <= mreq_nxt;
      align_exc_r <= align_exc_nxt;
    end
  end

  assign MSW = msw_r;
  assign PC = pc_r;
  assign LINK_ADDR = link_r;
  assign SAVED_PC = saved_r;
  assign MREQ = mreq_r;
  assign ALIGN_EXC = align_exc_r;

  chk_fetch_munge: assert property (@(posedge CLK) disable iff (!ARST_N)
    le_on |-> FETCH_ADDR == (pc_r ^ 32'h0000_0004)) else $error("fetch munge wrong");
  chk_be_passthru: assert property (@(posedge CLK) disable iff (!ARST_N)
    !le_on |-> FETCH_ADDR == pc_r) else $error("big-endian fetch modified");
  chk_seq_step: assert property (@(posedge CLK) disable iff (!ARST_N)
    FETCH_ADV && !BR_TAKE && !EXC_TAKE |=> PC == $past(PC) + 32'h0000_0004)
    else $error("sequential step not four");
  chk_exc_endian: assert property (@(posedge CLK) disable iff (!ARST_N)
    EXC_TAKE |=> MSW.little_endian_select == $past(MSW.exception_endian_select))
    else $error("exception endian not copied");
  chk_saved_pc: assert property (@(posedge CLK) disable iff (!ARST_N)
    EXC_TAKE |=> SAVED_PC == $past(PC)) else $error("saved address munged");
  chk_le_nonscalar: assert property (@(posedge CLK) disable iff (!ARST_N)
    DREQ.valid && le_on && DREQ.kind != ACC_SCALAR |=> ALIGN_EXC && !MREQ.valid)
    else $error("nonscalar not faulted");
  chk_aligned_norst: assert property (@(posedge CLK) disable iff (!ARST_N)
    DREQ.valid && DREQ.kind == ACC_SCALAR && d_aligned |=> !MREQ.restartable)
    else $error("aligned access restartable");
  chk_word_munge: assert property (@(posedge CLK) disable iff (!ARST_N)
    DREQ.valid && le_on && DREQ.kind == ACC_SCALAR && DREQ.size == SZ4 && d_aligned
    |=> MREQ.addr == ($past(DREQ.ea) ^ 32'h0000_0004)) else $error("word munge wrong");
  chk_rel_branch: assert property (@(posedge CLK) disable iff (!ARST_N)
    BR_TAKE && !BR_ABS && !EXC_TAKE |=> PC == $past(PC) + {$past(BR_OFFSET[31:2]), 2'h0})
    else $error("relative target wrong");
  cov_le_fetch: cover property (@(posedge CLK) disable iff (!ARST_N) le_on && FETCH_ADV);
  cov_align_exc: cover property (@(posedge CLK) disable iff (!ARST_N) ALIGN_EXC);
  cov_restart: cover property (@(posedge CLK) disable iff (!ARST_N) MREQ.restartable);
  cov_exc: cover property (@(posedge CLK) disable iff (!ARST_N) EXC_TAKE && le_on);
endmodule : le_addr_path

// >>> bench/mem_side.sv
`timescale 1ns/100ps
module mem_side
  import le_munge_pkg::*;
(
  input wire le_munge_pkg::mreq_t MREQ,
  input wire logic LE,
  input wire logic FETCH_LE,
  input wire logic [31:0] FETCH_ADDR,
  output logic [31:0] IO_ADDR,
  output logic [31:0] INSN_SLOT
);
  import le_munge_pkg::*;
  logic [2:0] unmunge;
  // Undo the core's munge so a true little-endian device sees byte order
  assign unmunge = !LE ? 3'h0 : MREQ.size == SZ1 ? 3'h7 : MREQ.size == SZ2 ? 3'h6 :
    MREQ.size == SZ4 ? 3'h4 : 3'h0;
  assign IO_ADDR = {MREQ.addr[31:3], MREQ.addr[2:0] ^ unmunge};
  // Loader stores each instruction pair swapped, so a munged fetch finds execution order
  assign INSN_SLOT = {FETCH_ADDR[31:3], FETCH_ADDR[2:0] ^ (FETCH_LE ? 3'h4 : 3'h0)};
endmodule : mem_side

// >>> bench/le_addr_path_bench.sv
`timescale 1ns/100ps
module le_addr_path_bench;
  import le_munge_pkg::*;
  logic CLK = 0, ARST_N = 0, MSW_WR = 0, EXC_TAKE = 0, FETCH_ADV = 0;
  logic BR_TAKE = 0, BR_ABS = 0, BR_LINK = 0, IN_BLOCK_AREA = 0, ALIGN_EXC;
  logic [31:0] EXC_VECTOR = '0, BR_OFFSET = '0, FETCH_ADDR, PC, LINK_ADDR, SAVED_PC, io_addr;
  logic [31:0] insn_slot;
  machine_state_word_t MSW_IN = '0, MSW, msw = '0;
  dreq_t DREQ = '0;
  mreq_t MREQ;
  opsize_t e_size;
  int error_cnt = 0, checked = 0, n;
  logic [31:0] pc = 32'h100, lnk = '0, sav = '0, e_addr, e_ea, r;
  logic e_val = 0, e_exc = 0, e_rst, e_sc, e_le = 0, le, sc;
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin error_cnt++; \
  $display("unexpected %s exp %h got %h", nm, e, g); end end
  always #2.5 CLK = ~CLK;
  le_addr_path dut(.CLK(CLK), .ARST_N(ARST_N), .MSW_WR(MSW_WR), .MSW_IN(MSW_IN),
    .EXC_TAKE(EXC_TAKE), .EXC_VECTOR(EXC_VECTOR), .FETCH_ADV(FETCH_ADV), .BR_TAKE(BR_TAKE),
    .BR_ABS(BR_ABS), .BR_LINK(BR_LINK), .BR_OFFSET(BR_OFFSET), .DREQ(DREQ),
    .IN_BLOCK_AREA(IN_BLOCK_AREA), .MSW(MSW), .FETCH_ADDR(FETCH_ADDR), .PC(PC),
    .LINK_ADDR(LINK_ADDR), .SAVED_PC(SAVED_PC), .MREQ(MREQ), .ALIGN_EXC(ALIGN_EXC));
  mem_side partner(.MREQ(MREQ), .LE(e_le), .FETCH_LE(msw.little_endian_select),
    .FETCH_ADDR(FETCH_ADDR), .IO_ADDR(io_addr), .INSN_SLOT(insn_slot));
  task automatic tally_and_finish;
    $display("compares %0d mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : tally_and_finish
  initial begin
    #100000;
    error_cnt++;
    tally_and_finish;
  end
  initial begin
    void'($urandom(32'hB73D));
    repeat (4) @(posedge CLK);
    #1 ARST_N = 1;
    for (int i = 0; i < 3000; i++) begin
      @(posedge CLK);
      #1;
      `CHK("ALIGN_EXC", e_exc, ALIGN_EXC)
      `CHK("MREQ.valid", e_val, MREQ.valid)
      if (e_val) begin
        `CHK("MREQ.addr", e_addr, MREQ.addr)
        `CHK("MREQ.size", e_size, MREQ.size)
        `CHK("restartable", e_rst, MREQ.restartable)
        if (e_sc) `CHK("io_addr", e_ea, io_addr)
      end
      `CHK("PC", pc, PC)
      `CHK("FETCH_ADDR", pc ^ (msw.little_endian_select ? 32'h4 : 32'h0), FETCH_ADDR)
      `CHK("INSN_SLOT", pc, insn_slot)
      `CHK("LINK_ADDR", lnk, LINK_ADDR)
      `CHK("SAVED_PC", sav, SAVED_PC)
      `CHK("MSW", msw, MSW)
      // Exception never shares a cycle with a branch or state write: priority is left open
      r = $urandom;
      EXC_TAKE = r[3:0] == 4'h0;
      MSW_WR = !EXC_TAKE && r[7:4] == 4'h0;
      MSW_IN = r[9:8];
      BR_TAKE = !EXC_TAKE && r[10] && r[11];
      BR_ABS = r[12];
      BR_LINK = r[13];
      FETCH_ADV = !EXC_TAKE && r[14];
      IN_BLOCK_AREA = r[15];
      EXC_VECTOR = $urandom & 32'hFFFF_FFFC;
      BR_OFFSET = $urandom;
      DREQ.valid = r[16];
      DREQ.kind = acc_kind_t'(r[18:17] % 3);
      DREQ.size = opsize_t'(r[20:19]);
      DREQ.ea = $urandom;
      if (r[21]) DREQ.ea[11:3] = '1;
      le = msw.little_endian_select;
      n = 1 << DREQ.size;
      sc = DREQ.kind == ACC_SCALAR;
      e_exc = DREQ.valid && ((le && (!sc || DREQ.ea[2:0] + n > 8)) ||
        (DREQ.kind == ACC_MULTIPLE && DREQ.ea[1:0] != 2'h0));
      e_val = DREQ.valid && !e_exc;
      e_sc = sc;
      e_le = le;
      e_ea = DREQ.ea;
      e_size = DREQ.size;
      e_addr = DREQ.ea ^ ((le && sc) ? 32'(8 - n) : 32'h0);
      e_rst = sc ? (((DREQ.ea & (n - 1)) != 0) &&
        ((DREQ.ea[11:0] + n > 4096 && !IN_BLOCK_AREA) || le)) :
        (DREQ.ea[11:0] + n > 4096 && !IN_BLOCK_AREA);
      if (EXC_TAKE) begin
        sav = pc;
        pc = EXC_VECTOR;
        msw.little_endian_select = msw.exception_endian_select;
      end else begin
        if (MSW_WR) msw = MSW_IN;
        if (BR_TAKE) begin
          if (BR_LINK) lnk = pc + 32'h4;
          pc = (BR_ABS ? 32'h0 : pc) + (BR_OFFSET & 32'hFFFF_FFFC);
        end else if (FETCH_ADV) pc = pc + 32'h4;
      end
    end
    $display("random path test done");
    tally_and_finish;
  end
endmodule : le_addr_path_bench
